// ---- src/swdt_top.sv ----
// Watchdog timer top: AXI4-Lite register slave, counter control and responses
//
// Contract
// - Timeout is made by a binary counter on the system clock that runs while enabled.
// - Select field bits 6-4 gives 2^15,2^17,2^19,2^21,2^23,2^25 clocks; 110/111 are forbidden.
// - Reaching the selected length without a clear signals a malfunction via the response.
// - Bit 1 picks the action: 0 raises the timeout interrupt, 1 an internal reset; resets to 1.
// - The timeout interrupt goes out as a non-maskable interrupt source.
// - Counting starts on reset release; enable bit 7 resets to 1 and 0 means disabled; the code keeps counting at 0 until the disable code is written.
// - Bit 2 decides idle mode: 0 halts the counter in idle, 1 keeps counting.
// - The write-only code register takes 0x4E as clear and 0xB1 as disable; others reserved.
// - The counter freezes during debug mode and resumes when it ends.
// - Disable needs enable cleared first, then the disable code, which stops and clears.
// - The clear code resets the counter to zero to start a fresh period.
// - A reset response holds the internal reset active for 32 states.
`timescale 1ns/10ps
module swdt_top
	import swdt_pkg::*;
#(
	parameter int CNT_W = 25
)
(
	// Clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        ARST_N_I,
	// AXI4-Lite write address
	input  wire logic [3:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	// AXI4-Lite write data
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	// AXI4-Lite write response
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	// AXI4-Lite read address
	input  wire logic [3:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	// AXI4-Lite read data
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	// Processor state
	input  wire logic        IDLE_MODE_I,
	input  wire logic        DEBUG_MODE_I,
	// Responses to the core
	output logic             TIMEOUT_NMI_O,
	output logic             INT_RESET_O,
	output logic             IRQ_O
);

	logic                   aw_hold_q;
	logic [3:0]             aw_addr_q;
	logic                   w_hold_q;
	logic [31:0]            w_data_q;
	logic [3:0]             w_strb_q;
	logic                   wr_go;
	logic                   wr_hit_mode;
	logic                   wr_hit_code;
	logic                   wr_hit_stat;
	logic                   wr_hit_mask;
	logic                   en_q;
	logic [2:0]             sel_q;
	logic                   idle_run_q;
	logic                   resp_sel_q;
	logic                   code_clear;
	logic                   code_disable;
	logic                   code_bad;
	logic                   run;
	logic                   expire;
	logic [SWDT_ST_W-1:0]   stat_q;
	logic [SWDT_ST_W-1:0]   mask_q;
	logic [SWDT_ST_W-1:0]   stat_set;
	swdt_rst_state_type     rst_st_q;
	logic [5:0]             rst_cnt_q;
	logic [31:0]            rd_word;

	////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are latched independently
	// Each ready is a flop that drops when its half is taken and comes back when
	// the response is accepted; same as "not held and no response pending", but
	// the port then leaves straight from a register and the bus timing stays clean
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			S_AXI_AWREADY_O <= 1'b1;
		else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
			S_AXI_AWREADY_O <= 1'b0;
		else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
			S_AXI_AWREADY_O <= 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			S_AXI_WREADY_O <= 1'b1;
		else if (S_AXI_WVALID_I && S_AXI_WREADY_O)
			S_AXI_WREADY_O <= 1'b0;
		else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
			S_AXI_WREADY_O <= 1'b1;
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
		end
		else if (wr_go)
			aw_hold_q <= 1'b0;
		else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
		begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= S_AXI_AWADDR_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			w_hold_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end
		else if (wr_go)
			w_hold_q <= 1'b0;
		else if (S_AXI_WVALID_I && S_AXI_WREADY_O)
		begin
			w_hold_q <= 1'b1;
			w_data_q <= S_AXI_WDATA_I;
			w_strb_q <= S_AXI_WSTRB_I;
		end
	end

	// Write executes one cycle after both halves are held
	assign wr_go       = aw_hold_q && w_hold_q;
	assign wr_hit_mode = wr_go && (aw_addr_q == SWDT_MODE_OFS) && w_strb_q[0];
	assign wr_hit_code = wr_go && (aw_addr_q == SWDT_CODE_OFS) && w_strb_q[0];
	assign wr_hit_stat = wr_go && (aw_addr_q == SWDT_STAT_OFS) && w_strb_q[0];
	assign wr_hit_mask = wr_go && (aw_addr_q == SWDT_MASK_OFS) && w_strb_q[0];

	// Write response; unmapped addresses get SLVERR
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O  <= SWDT_RESP_OKAY;
		end
		else if (wr_go)
		begin
			S_AXI_BVALID_O <= 1'b1;
			S_AXI_BRESP_O  <= (aw_addr_q[1:0] != 2'h0) ? SWDT_RESP_SLVERR : SWDT_RESP_OKAY;
		end
		else if (S_AXI_BREADY_I)
			S_AXI_BVALID_O <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register; reserved bit 0 is write-0 and not stored
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			en_q       <= SWDT_EN_RST;
			sel_q      <= SWDT_SEL_RST;
			idle_run_q <= SWDT_IDLE_RST;
			resp_sel_q <= SWDT_RESP_RST;
		end
		else if (wr_hit_mode)
		begin
			en_q       <= w_data_q[SWDT_EN_BIT];
			sel_q      <= w_data_q[SWDT_SEL_HI:SWDT_SEL_LO];
			idle_run_q <= w_data_q[SWDT_IDLE_BIT];
			resp_sel_q <= w_data_q[SWDT_RESP_BIT];
		end
	end

	// Code decode; disable only counts when enable is already clear
	assign code_clear   = wr_hit_code && (w_data_q[7:0] == SWDT_CODE_CLEAR);
	assign code_disable = wr_hit_code && (w_data_q[7:0] == SWDT_CODE_DISABLE) && !en_q;
	assign code_bad     = wr_hit_code && !code_clear && !code_disable;

	// Counter stops once the disable code has taken effect; setting enable restarts it
	logic stopped_q;
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			stopped_q <= 1'b0; // Running from reset release
		else if (wr_hit_mode && w_data_q[SWDT_EN_BIT])
			stopped_q <= 1'b0;
		else if (code_disable)
			stopped_q <= 1'b1;
	end

	// Idle and debug freeze the count without clearing it
	assign run = !stopped_q && !DEBUG_MODE_I && (!IDLE_MODE_I || idle_run_q);

	////////////////////////////////////////////////////////////////////////
	// Counter core
	swdt_counter #(
		.CNT_W    (CNT_W)
	) u_counter (
		.clk_i    (SYS_CLK_I),
		.arst_n_i (ARST_N_I),
		.run_i    (run),
		.clear_i  (code_clear || code_disable),
		.sel_i    (sel_q),
		.expire_o (expire)
	);

	////////////////////////////////////////////////////////////////////////
	// Non-maskable timeout request: held until the clear code or an accepted disable code arrives
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			TIMEOUT_NMI_O <= 1'b0;
		else if (expire && !resp_sel_q)
			TIMEOUT_NMI_O <= 1'b1; // A same-cycle clear wins: the counter holds expire low while clear_i is high
		else if (code_clear || code_disable)
			TIMEOUT_NMI_O <= 1'b0;
	end

	// Internal reset pulse of fixed length
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			rst_st_q    <= SWDT_IDLE_ST;
			rst_cnt_q   <= '0;
			INT_RESET_O <= 1'b0;
		end
		else
		begin
			case (rst_st_q)
				SWDT_IDLE_ST:
				begin
					if (expire && resp_sel_q)
					begin
						rst_st_q    <= SWDT_HOLD_ST;
						rst_cnt_q   <= 6'(SWDT_RST_STATES - 1);
						INT_RESET_O <= 1'b1;
					end
				end
				SWDT_HOLD_ST:
				begin
					if (rst_cnt_q == '0)
					begin
						rst_st_q    <= SWDT_IDLE_ST;
						INT_RESET_O <= 1'b0;
					end
					else
						rst_cnt_q <= rst_cnt_q - 6'h01;
				end
				default:
				begin
					rst_st_q    <= SWDT_IDLE_ST;
					INT_RESET_O <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status, write-one-to-clear; a new event wins over the clear
	assign stat_set[SWDT_ST_TIMEOUT] = expire && !resp_sel_q;
	assign stat_set[SWDT_ST_RESET]   = expire && resp_sel_q;
	assign stat_set[SWDT_ST_BADCODE] = code_bad;

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			stat_q <= '0;
		else
			stat_q <= stat_set | (stat_q & ~(wr_hit_stat ? w_data_q[SWDT_ST_W-1:0] : '0));
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			mask_q <= '0;
		else if (wr_hit_mask)
			mask_q <= w_data_q[SWDT_ST_W-1:0];
	end

	// Ordinary interrupt line; the NMI path above is never masked
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(stat_q & mask_q);
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; code register is write-only and reads zero
	always_comb
	begin
		rd_word = '0;
		case (S_AXI_ARADDR_I)
			SWDT_MODE_OFS:
			begin
				rd_word[SWDT_EN_BIT]               = en_q;
				rd_word[SWDT_SEL_HI:SWDT_SEL_LO]   = sel_q;
				rd_word[SWDT_IDLE_BIT]             = idle_run_q;
				rd_word[SWDT_RESP_BIT]             = resp_sel_q;
			end
			SWDT_STAT_OFS: rd_word[SWDT_ST_W-1:0] = stat_q;
			SWDT_MASK_OFS: rd_word[SWDT_ST_W-1:0] = mask_q;
			default:       rd_word = '0;
		endcase
	end

	// Read channel: one cycle from address to data; ready is low while data waits
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
			S_AXI_ARREADY_O <= 1'b1;
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
			S_AXI_ARREADY_O <= 1'b0;
		else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
			S_AXI_ARREADY_O <= 1'b1; // Data taken, a new address may follow
	end

	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O  <= '0;
			S_AXI_RRESP_O  <= SWDT_RESP_OKAY;
		end
		else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
		begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O  <= rd_word;
			S_AXI_RRESP_O  <= (S_AXI_ARADDR_I[1:0] != 2'h0) ? SWDT_RESP_SLVERR : SWDT_RESP_OKAY;
		end
		else if (S_AXI_RREADY_I)
			S_AXI_RVALID_O <= 1'b0;
	end

endmodule : swdt_top

// ---- src/swdt_pkg.sv ----
// Package of register map, field layout and timing constants for the watchdog
package swdt_pkg;

	// Register byte offsets
	localparam logic [3:0] SWDT_MODE_OFS = 4'h0;
	localparam logic [3:0] SWDT_CODE_OFS = 4'h4;
	localparam logic [3:0] SWDT_STAT_OFS = 4'h8;
	localparam logic [3:0] SWDT_MASK_OFS = 4'hC;

	// Mode register field positions
	localparam int SWDT_EN_BIT   = 7;
	localparam int SWDT_SEL_HI   = 6;
	localparam int SWDT_SEL_LO   = 4;
	localparam int SWDT_IDLE_BIT = 2;
	localparam int SWDT_RESP_BIT = 1;

	// Mode register reset values
	localparam logic       SWDT_EN_RST   = 1'h1;
	localparam logic [2:0] SWDT_SEL_RST  = 3'h0;
	localparam logic       SWDT_IDLE_RST = 1'h0;
	localparam logic       SWDT_RESP_RST = 1'h1;

	// Code register command values
	localparam logic [7:0] SWDT_CODE_CLEAR   = 8'h4E;
	localparam logic [7:0] SWDT_CODE_DISABLE = 8'hB1;

	// Timeout selection: exponent of the first code and step between codes
	localparam int SWDT_EXP_BASE = 15;
	localparam int SWDT_EXP_STEP = 2;
	localparam logic [2:0] SWDT_SEL_MAX = 3'h5;

	// Internal reset pulse length in system clock states
	localparam int SWDT_RST_STATES = 32;

	// Status bit positions
	localparam int SWDT_ST_TIMEOUT = 0;
	localparam int SWDT_ST_RESET   = 1;
	localparam int SWDT_ST_BADCODE = 2;
	localparam int SWDT_ST_W       = 3;

	// AXI responses
	localparam logic [1:0] SWDT_RESP_OKAY   = 2'h0;
	localparam logic [1:0] SWDT_RESP_SLVERR = 2'h2;

	// Reset pulse sequencer states
	typedef enum logic [1:0]
	{
		SWDT_IDLE_ST = 2'h0,
		SWDT_HOLD_ST = 2'h1
	} swdt_rst_state_type;

endpackage : swdt_pkg

// ---- src/swdt_counter.sv ----
// Binary counter of the watchdog with selectable expiry tap
`timescale 1ns/10ps
module swdt_counter
	import swdt_pkg::*;
#(
	parameter int CNT_W = 25
)
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	// Control
	input  wire logic       run_i,
	input  wire logic       clear_i,
	input  wire logic [2:0] sel_i,
	// Expiry
	output logic            expire_o
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W-1:0] last_q;
	logic [CNT_W-1:0] last_d;

	////////////////////////////////////////////////////////////////////////
	// Terminal count: 2^(15+2*sel)-1; codes above 101 treated as 101
	always_comb
	begin
		if (sel_i > SWDT_SEL_MAX)
			last_d = '1;
		else
			last_d = CNT_W'((64'h1 << (SWDT_EXP_BASE + SWDT_EXP_STEP * int'(sel_i))) - 64'h1);
	end

	// Registered so the comparator path is short
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			last_q <= '0;
		else
			last_q <= last_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Count while running, restart from zero on clear or on expiry
	always_comb
	begin
		cnt_d = cnt_q;
		if (clear_i)
			cnt_d = '0;
		else if (run_i)
			cnt_d = expire_o ? '0 : cnt_q + CNT_W'(1);
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

	// Expiry when the count reaches the terminal value of the selected length
	assign expire_o = run_i && !clear_i && (cnt_q == last_q) && (last_q != '0);

endmodule : swdt_counter

// ---- dv/swdt_core_model.sv ----
// Behavioural model of the core NMI input and reset sequencer facing the watchdog
`timescale 1ns/10ps
module swdt_core_model
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// Requests from the watchdog
	input  wire logic nmi_i,
	input  wire logic reset_req_i,
	// Observations for the bench
	output logic [7:0] pulse_len_o,
	output logic [7:0] nmi_count_o
);
	logic [7:0] len_q;
	logic       nmi_q;

	////////////////////////////////////////////////////////////////////////////
	// Reset sequencer: length of each request is latched when it ends
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			len_q       <= 8'h00;
			pulse_len_o <= 8'h00;
		end
		else if (reset_req_i)
			len_q <= len_q + 8'h01;
		else if (len_q != 8'h00)
		begin
			pulse_len_o <= len_q;
			len_q       <= 8'h00;
		end

	// NMI input is edge sensitive and cannot be masked, so count rising edges
	always_ff @(posedge clk_i or negedge arst_n_i)
		if (!arst_n_i)
		begin
			nmi_q       <= 1'h0;
			nmi_count_o <= 8'h00;
		end
		else
		begin
			nmi_q <= nmi_i;
			if (nmi_i && !nmi_q)
				nmi_count_o <= nmi_count_o + 8'h01;
		end
endmodule : swdt_core_model

// ---- dv/swdt_top_checker.sv ----
// Concurrent checks on the ports of the watchdog top
`timescale 1ns/10ps
module swdt_top_checker
#(
	parameter int CNT_W = 25
)
(
	input wire logic        SYS_CLK_I,
	input wire logic        ARST_N_I,
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_WVALID_I,
	input wire logic [1:0]  S_AXI_BRESP_O,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_BREADY_I,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        S_AXI_RVALID_O,
	input wire logic        S_AXI_RREADY_I,
	input wire logic        DEBUG_MODE_I,
	input wire logic        TIMEOUT_NMI_O,
	input wire logic        INT_RESET_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!ARST_N_I);
	logic [5:0]  rcnt_q;
	logic [15:0] scnt_q;

	////////////////////////////////////////////////////////////////////////////
	// Length of the reset request so far, and edges since reset saturating
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
			rcnt_q <= 6'h00;
		else
			rcnt_q <= INT_RESET_O ? rcnt_q + 6'h01 : 6'h00;
	always_ff @(posedge SYS_CLK_I or negedge ARST_N_I)
		if (!ARST_N_I)
			scnt_q <= 16'h0000;
		else if (scnt_q != 16'hFFFF)
			scnt_q <= scnt_q + 16'h0001;

	rst_short_a: assert property (INT_RESET_O |-> rcnt_q < 6'h20)
		else $error("reset request held too long");
	rst_len_a: assert property ($fell(INT_RESET_O) |-> rcnt_q == 6'h20)
		else $error("reset request not 32 cycles");
	nmi_hold_a: assert property ($rose(TIMEOUT_NMI_O) && !S_AXI_AWVALID_I
		&& !S_AXI_WVALID_I && !S_AXI_BVALID_O |=> TIMEOUT_NMI_O)
		else $error("nmi dropped with no write");
	one_resp_a: assert property ($rose(INT_RESET_O) |-> !$rose(TIMEOUT_NMI_O))
		else $error("both responses on one expiry");
	first_expiry_a: assert property ($rose(TIMEOUT_NMI_O) || $rose(INT_RESET_O)
		|-> scnt_q >= 16'h7FFF)
		else $error("expiry before shortest timeout");
	debug_freeze_a: assert property (DEBUG_MODE_I [*3] |-> !$rose(TIMEOUT_NMI_O)
		&& !$rose(INT_RESET_O))
		else $error("expiry while in debug");
	bresp_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
		|=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write response not held");
	rdata_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
		|=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read data not held");
endmodule : swdt_top_checker

bind swdt_top swdt_top_checker #(.CNT_W(CNT_W)) u_chk (.SYS_CLK_I(SYS_CLK_I),
	.ARST_N_I(ARST_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
	.S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_RDATA_O(S_AXI_RDATA_O),
	.S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
	.DEBUG_MODE_I(DEBUG_MODE_I), .TIMEOUT_NMI_O(TIMEOUT_NMI_O), .INT_RESET_O(INT_RESET_O));

// ---- dv/swdt_top_test.sv ----
// Self-checking bench of the watchdog top over its register bus
`timescale 1ns/10ps
module swdt_top_test;
	import swdt_pkg::*;
	logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready, idle, dbg;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdat;
	logic [1:0]  rsp;
	wire         awready, wready, bvalid, arready, rvalid, nmi, irst, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [7:0]  plen, ncnt;
	int          n_errors = 0, cmp_count = 0, cyc = 0, t0 = 0;

	swdt_top DUT (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .S_AXI_AWADDR_I(awaddr),
		.S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
		.S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .IDLE_MODE_I(idle), .DEBUG_MODE_I(dbg),
		.TIMEOUT_NMI_O(nmi), .INT_RESET_O(irst), .IRQ_O(irq));
	swdt_core_model u_core (.clk_i(clk), .arst_n_i(arst_n), .nmi_i(nmi), .reset_req_i(irst),
		.pulse_len_o(plen), .nmi_count_o(ncnt));

	////////////////////////////////////////////////////////////////////////////
	// Clock, and a ceiling a little above the three waits of one shortest timeout each
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 100000)
		begin
			n_errors++;
			close_out();
		end
	end

	task close_out();
		if (n_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// Ready is looked at on the falling edge so the taking edge is never raced
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		fork
			begin
				do @(negedge clk); while (awready !== 1'b1);
				@(posedge clk);
				awvalid <= 1'b0;
			end
			begin
				do @(negedge clk); while (wready !== 1'b1);
				@(posedge clk);
				wvalid <= 1'b0;
			end
		join
		do @(negedge clk); while (bvalid !== 1'b1);
		// Ready comes a cycle late so the slave must hold its response meanwhile
		@(posedge clk);
		bready <= 1'b1;
		@(negedge clk);
		rsp = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		// Ready comes a cycle late so the slave must hold its data meanwhile
		@(posedge clk);
		rready <= 1'b1;
		@(negedge clk);
		rdat = rdata;
		rsp  = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask : rd

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{arst_n, awvalid, wvalid, bready, arvalid, rready, idle, dbg} <= 8'h00;
		{awaddr, araddr, wdata} <= '0;
		wstrb <= 4'hF;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t0 = cyc;
		rd(SWDT_MODE_OFS); cmp(rdat, 32'h00000082);
		rd(SWDT_CODE_OFS); cmp(rdat, 32'h00000000);
		rd(4'h2); cmp(32'(rsp), 32'(SWDT_RESP_SLVERR));
		wr(4'h1, 32'(SWDT_CODE_CLEAR)); cmp(32'(rsp), 32'(SWDT_RESP_SLVERR));
		// Default response is a reset after the shortest timeout from release
		while (irst !== 1'b1) @(negedge clk);
		cmp(32'(cyc - t0 >= 32760 && cyc - t0 <= 32780), 32'h1);
		while (irst !== 1'b0) @(negedge clk);
		// The core model latches the length one edge after the request ends
		@(negedge clk);
		cmp(32'(plen), 32'(SWDT_RST_STATES));
		cmp(32'(nmi), 32'h0);
		rd(SWDT_STAT_OFS); cmp(rdat, 32'h00000002);
		cmp(32'(irq), 32'h0);
		wr(SWDT_STAT_OFS, 32'h00000002);
		rd(SWDT_STAT_OFS); cmp(rdat, 32'h00000000);
		wr(SWDT_MASK_OFS, 32'h00000001);
		for (int i = 0; i < 6; i++)
		begin
			wr(SWDT_MODE_OFS, 32'h80 | (i << 4));
			rd(SWDT_MODE_OFS); cmp(rdat, 32'h80 | (i << 4));
		end
		// Interrupt response; debug and idle each freeze the count for 100 cycles
		wr(SWDT_MODE_OFS, 32'h00000080);
		wr(SWDT_CODE_OFS, 32'(SWDT_CODE_CLEAR));
		t0 = cyc;
		@(posedge clk) dbg <= 1'b1;
		repeat (100) @(posedge clk);
		dbg  <= 1'b0;
		idle <= 1'b1;
		repeat (100) @(posedge clk);
		idle <= 1'b0;
		while (nmi !== 1'b1) @(negedge clk);
		cmp(32'(cyc - t0 >= 32960 && cyc - t0 <= 32980), 32'h1);
		repeat (2) @(negedge clk);
		cmp(32'(irq), 32'h1);
		wr(SWDT_CODE_OFS, 32'h00000012); cmp(32'(nmi), 32'h1);
		rd(SWDT_STAT_OFS); cmp(rdat, 32'h00000005);
		wr(SWDT_CODE_OFS, 32'(SWDT_CODE_DISABLE)); cmp(32'(nmi), 32'h1);
		wr(SWDT_STAT_OFS, 32'h00000005);
		repeat (2) @(negedge clk);
		cmp(32'(irq), 32'h0);
		wr(SWDT_CODE_OFS, 32'(SWDT_CODE_CLEAR)); cmp(32'(nmi), 32'h0);
		// Two-step disable then a wait past a full timeout
		wr(SWDT_MODE_OFS, 32'h00000000);
		wr(SWDT_CODE_OFS, 32'(SWDT_CODE_DISABLE));
		repeat (32900) @(posedge clk);
		cmp(32'({nmi, irst}), 32'h0);
		cmp(32'(ncnt), 32'h1);
		close_out();
	end
endmodule : swdt_top_test
